// File: src/dlr_pkg.sv
// Shared constants and carriers for the dual lane loop-back router.
// Assumes a single 200 MHz reference clock for every consumer.
`default_nettype none

package dlr_pkg;

   // Clock rate, expressed as its period
   localparam int unsigned CLK_PERIOD_PS = 5000;

   // Lock acquisition after link loss, typical figure, and its cycle count
   localparam int unsigned LOCK_TIME_NS  = 4000;
   localparam int unsigned LOCK_CYC      =
      (LOCK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // Accepted samples without a transition before a lane counts as lost
   localparam int unsigned LOSS_SAMPLES  = 64;

   // Counter widths for the lock and loss timers
   localparam int unsigned LOCK_W        = 12;
   localparam int unsigned LOSS_W        = 8;

   // Depth of the buffer between the retiming and the output stage
   localparam int unsigned FIFO_DEPTH    = 4;

   // Reset values of the serial outputs and lock flags
   localparam logic        OUT_RST       = 1'b0;
   localparam logic        LOCK_RST      = 1'b0;

   // Routing modes, one-hot
   typedef enum logic [3:0] {
      DLR_NORMAL  = 4'b0001,
      DLR_LOOP_A  = 4'b0010,
      DLR_LOOP_B  = 4'b0100,
      DLR_LOOP_AB = 4'b1000
   } dlr_mode_e;

   // One retimed sample of both lanes
   typedef struct packed {
      logic lane_b;
      logic lane_a;
   } dlr_pair_s;

   // Raw loop-back select pins with their drive-present flags
   typedef struct packed {
      logic lane_a_loopback_sel_n;
      logic lane_a_loopback_driven;
      logic lane_b_loopback_sel_n;
      logic lane_b_loopback_driven;
   } dlr_sel_s;

   localparam int unsigned PAIR_W = $bits(dlr_pair_s);

endpackage

`default_nettype wire

// File: src/dlr_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; pushes and pops in the same cycle are allowed.
`timescale 1ns/1ps
`default_nettype none

module dlr_fifo #(
   parameter int unsigned WIDTH = 2,
   parameter int unsigned DEPTH = 4
) (
   input  wire  logic             ref_clk,
   input  wire  logic             sys_rst,
   input  wire  logic [WIDTH-1:0] in_data,
   input  wire  logic             in_valid,
   output logic                   in_ready,
   output logic [WIDTH-1:0]       out_data,
   output logic                   out_valid,
   input  wire  logic             out_ready
);
   import dlr_pkg::*;

   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // Depth must be a power of two so the pointers wrap by themselves
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
      $error("dlr_fifo: DEPTH must be a power of two >= 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 cnt;
   } dlr_fifo_s;

   dlr_fifo_s st;
   dlr_fifo_s next_st;
   logic      push;
   logic      pop;

   // Full and empty come straight from the occupancy count
   assign in_ready  = (st.cnt != (AW + 1)'(DEPTH));
   assign out_valid = (st.cnt != '0);
   assign out_data  = st.mem[st.rd];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Pointer and count update
   always_comb begin
      next_st = st;
      if (push) begin
         next_st.mem[st.wr] = in_data;
         next_st.wr         = st.wr + 1'b1;
      end
      if (pop) begin
         next_st.rd = st.rd + 1'b1;
      end
      next_st.cnt = st.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule

`default_nettype wire

// File: src/dlr_router.sv
// Dual lane loop-back router: retimes two serial lanes and routes them
// to the two serial outputs according to two active-low loop-back pins.
// Assumes all inputs are synchronous to ref_clk; each serial bit arrives
// with rx_valid and leaves with tx_valid, both under valid/ready.
//
// Behaviour
// - Normal mode: retimed port A input drives the port B output.
// - Normal mode: retimed port B input drives the port A output.
// - Loop-back A alone: port A data still drives the port B output.
// - Loop-back A: port A data also on port A output; port B dropped.
// - Loop-back B alone: port B data still drives the port A output.
// - Loop-back B: port B data also on port B output; port A dropped.
// - Both loop-backs: each input returns on its own side's output.
// - After link loss each lane relocks after LOCK_CYCLES input transitions, 4 us at one per cycle; errors allowed.
`timescale 1ns/1ps
`default_nettype none

module dlr_router #(
   parameter int unsigned LOSS_LIMIT = dlr_pkg::LOSS_SAMPLES,
   parameter int unsigned LOCK_CYCLES = dlr_pkg::LOCK_CYC,
   parameter int unsigned BUF_DEPTH  = dlr_pkg::FIFO_DEPTH
) (
   input  wire  logic             ref_clk,
   input  wire  logic             sys_rst,
   input  wire  dlr_pkg::dlr_sel_s loopback_pins,
   input  wire  logic             port_a_serial_in,
   input  wire  logic             port_b_serial_in,
   input  wire  logic             rx_valid,
   output logic                   rx_ready,
   output logic                   port_a_serial_out,
   output logic                   port_b_serial_out,
   output logic                   tx_valid,
   input  wire  logic             tx_ready,
   output logic                   lane_a_locked,
   output logic                   lane_b_locked,
   output dlr_pkg::dlr_mode_e     route_mode
);
   import dlr_pkg::*;

   // Path of one pair: accepted into the buffer on one edge, moved to the
   // output slot on the next, then held there until the far side takes it.
   // The buffer absorbs short stalls so the receivers are not held off at
   // once; a deeper buffer absorbs longer stalls and adds no latency.

   // Timers must fit their counters; refused at elaboration so a bad
   // override never leaves a silently truncated count behind
   if (LOCK_CYCLES < 1 || LOCK_CYCLES >= (1 << LOCK_W)) begin : g_bad_lock
      $error("dlr_router: LOCK_CYCLES out of range");
   end
   if (LOSS_LIMIT < 1 || LOSS_LIMIT >= (1 << LOSS_W)) begin : g_bad_loss
      $error("dlr_router: LOSS_LIMIT out of range");
   end

   localparam logic [LOCK_W-1:0] LOCK_LOAD = LOCK_W'(LOCK_CYCLES);
   localparam logic [LOSS_W-1:0] LOSS_TOP  = LOSS_W'(LOSS_LIMIT);

   // Per-lane lock tracking state
   typedef struct packed {
      logic              last;
      logic [LOSS_W-1:0] quiet;
      logic [LOCK_W-1:0] lock_cnt;
      logic              locked;
   } dlr_lane_s;

   // Whole state of the router
   typedef struct packed {
      dlr_mode_e    mode;
      dlr_lane_s    lane_a;
      dlr_lane_s    lane_b;
      logic         out_a;
      logic         out_b;
      logic         out_valid;
   } dlr_state_s;

   dlr_state_s st;
   dlr_state_s next_st;

   // Nets between the pins, the buffer and the output stage
   dlr_pair_s  in_pair;
   dlr_pair_s  buf_pair;
   logic       buf_valid;
   logic       buf_ready;
   logic       accept;
   logic       sel_a_low;
   logic       sel_b_low;

   // An undriven pin is pulled up, so only a driven low selects loop-back
   assign sel_a_low = loopback_pins.lane_a_loopback_driven
                      && !loopback_pins.lane_a_loopback_sel_n;
   assign sel_b_low = loopback_pins.lane_b_loopback_driven
                      && !loopback_pins.lane_b_loopback_sel_n;

   // Both lane bits travel as one pair so they stay aligned
   assign in_pair.lane_a = port_a_serial_in;
   assign in_pair.lane_b = port_b_serial_in;
   assign accept         = rx_valid && rx_ready;

   // Retiming buffer; its fill level is what pushes back on the receivers
   dlr_fifo #(
      .WIDTH (PAIR_W),
      .DEPTH (BUF_DEPTH)
   ) u_buf (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .in_data   (in_pair),
      .in_valid  (rx_valid),
      .in_ready  (rx_ready),
      .out_data  (buf_pair),
      .out_valid (buf_valid),
      .out_ready (buf_ready)
   );

   // The output stage takes a new pair when its holding slot frees up
   assign buf_ready = !st.out_valid || tx_ready;

   // Relock timer for one lane; a lane with no transition for LOSS_LIMIT
   // accepted samples is treated as down and must count out again
   // Transitions are counted rather than cycles: only edges carry timing
   function automatic dlr_lane_s lane_step(
      input dlr_lane_s cur,
      input logic      bit_in,
      input logic      take
   );
      dlr_lane_s nx;
      nx = cur;
      if (take) begin
         nx.last = bit_in;
         if (bit_in != cur.last) begin
            nx.quiet = '0;
            if (cur.lock_cnt != '0) begin
               nx.lock_cnt = cur.lock_cnt - 1'b1;
            end
         end else if (cur.quiet != LOSS_TOP) begin
            nx.quiet = cur.quiet + 1'b1;
         end
         if (nx.quiet == LOSS_TOP) begin
            nx.lock_cnt = LOCK_LOAD;
         end
      end
      nx.locked = (nx.lock_cnt == '0);
      return nx;
   endfunction

   // Mode decode, lock tracking and output multiplexing
   always_comb begin
      next_st = st;

      // Pins are sampled every cycle; a change applies from the next pair
      case ({sel_b_low, sel_a_low})
         2'b01:   next_st.mode = DLR_LOOP_A;
         2'b10:   next_st.mode = DLR_LOOP_B;
         2'b11:   next_st.mode = DLR_LOOP_AB;
         default: next_st.mode = DLR_NORMAL;
      endcase

      // Data keeps flowing while unlocked: bit errors are tolerated then
      next_st.lane_a = lane_step(st.lane_a, port_a_serial_in, accept);
      next_st.lane_b = lane_step(st.lane_b, port_b_serial_in, accept);

      // A taken pair frees the slot; a load in the same cycle wins
      if (tx_ready) begin
         next_st.out_valid = 1'b0;
      end
      // Routing uses the registered mode, so a pin change also applies
      // to pairs that are already waiting in the buffer
      if (buf_valid && buf_ready) begin
         next_st.out_valid = 1'b1;
         case (st.mode)
            DLR_NORMAL: begin
               next_st.out_b = buf_pair.lane_a;
               next_st.out_a = buf_pair.lane_b;
            end
            DLR_LOOP_A: begin
               next_st.out_b = buf_pair.lane_a;
               next_st.out_a = buf_pair.lane_a;
            end
            DLR_LOOP_B: begin
               next_st.out_a = buf_pair.lane_b;
               next_st.out_b = buf_pair.lane_b;
            end
            DLR_LOOP_AB: begin
               next_st.out_a = buf_pair.lane_a;
               next_st.out_b = buf_pair.lane_b;
            end
            default: begin
               next_st.out_b = buf_pair.lane_a;
               next_st.out_a = buf_pair.lane_b;
            end
         endcase
      end
   end

   // State register; lanes start unlocked with a full relock count
   // Mode starts normal, as with both select pins left undriven
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st                 <= '0;
         st.mode            <= DLR_NORMAL;
         st.lane_a.lock_cnt <= LOCK_LOAD;
         st.lane_b.lock_cnt <= LOCK_LOAD;
         st.lane_a.locked   <= LOCK_RST;
         st.lane_b.locked   <= LOCK_RST;
         st.out_a           <= OUT_RST;
         st.out_b           <= OUT_RST;
      end else begin
         st <= next_st;
      end
   end

   // All data and status outputs come from the state register
   // Registered outputs keep a mode change from glitching the far side
   assign port_a_serial_out = st.out_a;
   assign port_b_serial_out = st.out_b;
   assign tx_valid          = st.out_valid;
   assign lane_a_locked     = st.lane_a.locked;
   assign lane_b_locked     = st.lane_b.locked;
   assign route_mode        = st.mode;

endmodule

`default_nettype wire

// File: verif/dlr_router_chk.sv
// Port checker for the loop-back router: mode, routing, hold, lock.
// Assumes it is bound into every router instance, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module dlr_router_chk
   import dlr_pkg::*;
#(
   parameter int unsigned LOCK_CYCLES = 8
) (
   input wire logic      ref_clk,
   input wire logic      sys_rst,
   input wire dlr_sel_s  loopback_pins,
   input wire logic      port_a_serial_in,
   input wire logic      port_b_serial_in,
   input wire logic      rx_valid,
   input wire logic      rx_ready,
   input wire logic      port_a_serial_out,
   input wire logic      port_b_serial_out,
   input wire logic      tx_valid,
   input wire logic      tx_ready,
   input wire logic      lane_a_locked,
   input wire logic      lane_b_locked,
   input wire dlr_mode_e route_mode
);
   logic        a_on;
   logic        b_on;
   logic [15:0] n_acc;
   // A select counts only when driven low; undriven reads high
   assign a_on = !loopback_pins.lane_a_loopback_sel_n &&
                 loopback_pins.lane_a_loopback_driven;
   assign b_on = !loopback_pins.lane_b_loopback_sel_n &&
                 loopback_pins.lane_b_loopback_driven;
   // Accepted pairs since reset; saturates so it never wraps back
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst)
         n_acc <= '0;
      else if (rx_valid && rx_ready && n_acc != '1)
         n_acc <= n_acc + 1'b1;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   chk_mode_norm: assert property (!a_on && !b_on |=>
      route_mode == DLR_NORMAL) else $error("mode not normal");
   chk_mode_loopa: assert property (a_on && !b_on |=>
      route_mode == DLR_LOOP_A) else $error("mode not loop a");
   chk_mode_loopb: assert property (!a_on && b_on |=>
      route_mode == DLR_LOOP_B) else $error("mode not loop b");
   chk_mode_both: assert property (a_on && b_on |=>
      route_mode == DLR_LOOP_AB) else $error("mode not both");
   // A freshly loaded pair was routed by the previous cycle's mode
   chk_loopa_same: assert property (tx_valid &&
      (!$past(tx_valid) || $past(tx_ready)) &&
      $past(route_mode) == DLR_LOOP_A
      |-> port_a_serial_out == port_b_serial_out)
      else $error("loop a outputs differ");
   chk_loopb_same: assert property (tx_valid &&
      (!$past(tx_valid) || $past(tx_ready)) &&
      $past(route_mode) == DLR_LOOP_B
      |-> port_a_serial_out == port_b_serial_out)
      else $error("loop b outputs differ");
   chk_out_hold: assert property (tx_valid && !tx_ready |=>
      tx_valid && $stable({port_a_serial_out, port_b_serial_out}))
      else $error("output pair not held");
   chk_lock_early: assert property ($rose(lane_a_locked) ||
      $rose(lane_b_locked) |-> n_acc >= LOCK_CYCLES)
      else $error("lock before enough pairs");
   cover property (a_on && b_on);
   cover property (tx_valid && !tx_ready);
   cover property ($rose(lane_a_locked));
endmodule
bind dlr_router dlr_router_chk #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .loopback_pins(loopback_pins),
   .port_a_serial_in(port_a_serial_in), .port_b_serial_in(port_b_serial_in),
   .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_valid(tx_valid),
   .port_a_serial_out(port_a_serial_out), .tx_ready(tx_ready),
   .port_b_serial_out(port_b_serial_out), .lane_a_locked(lane_a_locked),
   .lane_b_locked(lane_b_locked), .route_mode(route_mode));
`default_nettype wire

// File: verif/dlr_sink.sv
// Far-side receiver model: takes routed pairs and queues them in order.
// Assumes the bench drives stall off the rising edge.
`timescale 1ns/1ps
`default_nettype none
module dlr_sink
   import dlr_pkg::*;
(
   input wire logic  ref_clk,
   input wire logic  sys_rst,
   input wire logic  stall,
   input wire logic  tx_valid,
   input wire logic  out_a,
   input wire logic  out_b,
   output var logic  tx_ready
);
   dlr_pair_s got [$];
   // Stall gives back-pressure so held outputs can be watched
   assign tx_ready = !stall;
   // A pair counts only on the edge where both sides agree
   always @(posedge ref_clk) begin
      if (!sys_rst && tx_valid && tx_ready)
         got.push_back({out_b, out_a});
   end
endmodule
`default_nettype wire

// File: verif/dlr_router_test.sv
// Self-checking bench for the router: modes, back-pressure, lock.
// Assumes short lock counts so the run stays brief.
`timescale 1ns/1ps
`default_nettype none
module dlr_router_test;
   import dlr_pkg::*;
   logic      ref_clk;
   logic      sys_rst;
   dlr_sel_s  pins;
   logic      a_in;
   logic      b_in;
   logic      rx_valid;
   logic      rx_ready;
   logic      a_out;
   logic      b_out;
   logic      tx_valid;
   logic      tx_ready;
   logic      a_lock;
   logic      b_lock;
   dlr_mode_e mode;
   logic      stall;
   int        n_fail;
   int        checks;
   dlr_router #(.LOSS_LIMIT(4), .LOCK_CYCLES(8), .BUF_DEPTH(4)) dut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .loopback_pins(pins),
      .port_a_serial_in(a_in), .port_b_serial_in(b_in),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .port_a_serial_out(a_out),
      .port_b_serial_out(b_out), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .lane_a_locked(a_lock), .lane_b_locked(b_lock), .route_mode(mode));
   dlr_sink u_sink (.ref_clk(ref_clk), .sys_rst(sys_rst), .stall(stall),
      .tx_valid(tx_valid), .out_a(a_out), .out_b(b_out),
      .tx_ready(tx_ready));
   // Free-running 200 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task automatic summarize();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic give_up();
      n_fail++;
      $display("MISMATCH wait expected done seen timeout");
      summarize();
   endtask
   task automatic chk_pair(input string nm, input dlr_pair_s e,
                           input dlr_pair_s s);
      checks++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %b seen %b", nm, e, s);
      end
   endtask
   task automatic chk_bit(input string nm, input logic e, input logic s);
      chk_pair(nm, {1'b0, e}, {1'b0, s});
   endtask
   task automatic chk_mode(input dlr_mode_e e);
      chk_pair("mode_lo", e[1:0], mode[1:0]);
      chk_pair("mode_hi", e[3:2], mode[3:2]);
   endtask
   // Offer one pair and hold it until the router accepts it
   task automatic send(input logic a, input logic b);
      int k;
      @(negedge ref_clk);
      a_in = a;
      b_in = b;
      rx_valid = 1'b1;
      for (k = 0; k < 50 && rx_ready !== 1'b1; k++)
         @(negedge ref_clk);
      if (k == 50)
         give_up();
      @(posedge ref_clk);
   endtask
   task automatic idle();
      @(negedge ref_clk);
      rx_valid = 1'b0;
   endtask
   task automatic drain(input int n);
      int k;
      for (k = 0; k < 100 && u_sink.got.size() < n; k++)
         @(negedge ref_clk);
      if (k == 100)
         give_up();
   endtask
   // Settle the mode pins, then pass the four bit combinations
   task automatic pass4(input dlr_sel_s p);
      @(negedge ref_clk);
      pins = p;
      repeat (3) @(negedge ref_clk);
      u_sink.got.delete();
      for (int i = 0; i < 4; i++)
         send(i[0], i[1]);
      idle();
      drain(4);
   endtask
   function automatic dlr_pair_s exp_pair(input dlr_mode_e m, input int i);
      logic a;
      logic b;
      a = i[0];
      b = i[1];
      case (m)
         DLR_NORMAL: return {a, b};
         DLR_LOOP_A: return {a, a};
         DLR_LOOP_B: return {b, b};
         default:    return {b, a};
      endcase
   endfunction
   task automatic t_mode(input dlr_sel_s p, input dlr_mode_e m);
      pass4(p);
      chk_mode(m);
      for (int i = 0; i < 4; i++)
         chk_pair("pair", exp_pair(m, i), u_sink.got[i]);
   endtask
   // Stalled receiver: five pairs fill buffer and output stage
   task automatic t_fill();
      stall = 1'b1;
      u_sink.got.delete();
      for (int i = 0; i < 5; i++)
         send(i[0], !i[0]);
      idle();
      chk_bit("rx_ready_full", 1'b0, rx_ready);
      stall = 1'b0;
      drain(5);
      for (int i = 0; i < 5; i++)
         chk_pair("fill", {i[0], !i[0]}, u_sink.got[i]);
   endtask
   // Lock needs eight transitions; six flat pairs lose it again
   task automatic t_lock();
      chk_bit("lock_a_rst", 1'b0, a_lock);
      for (int i = 0; i < 12; i++)
         send(i[0], !i[0]);
      idle();
      repeat (2) @(negedge ref_clk);
      chk_bit("lock_a", 1'b1, a_lock);
      chk_bit("lock_b", 1'b1, b_lock);
      for (int i = 0; i < 6; i++)
         send(1'b0, 1'b0);
      idle();
      repeat (2) @(negedge ref_clk);
      chk_bit("loss_a", 1'b0, a_lock);
      chk_bit("loss_b", 1'b0, b_lock);
   endtask
   // Reset held two cycles, then every scenario in turn
   initial begin
      n_fail = 0;
      checks = 0;
      sys_rst = 1'b1;
      pins = 4'hF;
      a_in = 1'b0;
      b_in = 1'b0;
      rx_valid = 1'b0;
      stall = 1'b0;
      repeat (2) @(negedge ref_clk);
      sys_rst = 1'b0;
      t_lock();
      t_mode(4'hF, DLR_NORMAL);
      t_fill();
      t_mode(4'h0, DLR_NORMAL);
      t_mode(4'h7, DLR_LOOP_A);
      t_mode(4'hD, DLR_LOOP_B);
      t_mode(4'h5, DLR_LOOP_AB);
      summarize();
   end
endmodule
`default_nettype wire
